// ===== ebw_ctrl.sv
// External bus controller: read/write strobes and ready-driven wait states
`timescale 1ns/100ps
`default_nettype none
module ebw_ctrl #(
  parameter int unsigned WAIT_W = ebw_pkg::WAIT_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Access request from memory controller
  input  wire logic              req,
  input  wire logic              req_external,
  input  wire logic              req_write,
  input  wire logic [1:0]        req_bytes,
  output logic                   done,
  // Configuration
  input  wire logic              bus16,
  input  wire logic [WAIT_W-1:0] wait_limit,
  input  wire logic              sel_split_low,
  input  wire logic              sel_split_high,
  // External bus pins
  input  wire logic              ready_pin,
  output logic                   read_n,
  output logic                   write_n,
  output logic                   write_low_byte_n,
  output logic                   write_high_byte_n,
  output logic                   pin_low_strobe_n,
  output logic                   pin_high_strobe_n,
  output logic                   byte_high_enable_n,
  output logic                   busy
);
  import ebw_pkg::*;

  // ----------------------------------------------------------------
  // Ready synchronisation
  // ----------------------------------------------------------------
  logic ready;
  ebw_sync u_ready_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (ready_pin),
    .level (ready)
  );

  // ----------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------
  ebw_state_t        state;
  logic [WAIT_W-1:0] wait_cnt;
  logic              cur_write;
  logic [1:0]        cur_bytes;
  logic              end_cycle;

  // Wait ends on ready or on limit, whichever first
  assign end_cycle = ready || (wait_cnt >= wait_limit);

  // State register; internal accesses finish at once, ready unseen
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= EBW_IDLE;
    end else begin
      unique case (state)
        EBW_IDLE: begin
          if (req && req_external) begin
            state <= EBW_DATA;
          end
        end
        EBW_DATA: begin
          if (end_cycle) begin
            state <= EBW_IDLE;
          end else begin
            state <= EBW_WAIT;
          end
        end
        EBW_WAIT: begin
          if (end_cycle) begin
            state <= EBW_IDLE;
          end
        end
      endcase
    end
  end

  // Wait counter, restarted for each external cycle; cleared as a cycle ends
  // so that no stale count is left standing while idle
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_cnt <= '0;
    end else if (state == EBW_IDLE || end_cycle) begin
      wait_cnt <= '0;
    end else if (!end_cycle) begin
      wait_cnt <= wait_cnt + 1'b1;
    end
  end

  // Latch access attributes at the start of an external cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_write <= 1'b0;
      cur_bytes <= BYTE_WORD;
    end else if (state == EBW_IDLE && req && req_external) begin
      cur_write <= req_write;
      cur_bytes <= req_bytes;
    end
  end

  // Completion pulse; internal accesses never wait on ready
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= (state == EBW_IDLE && req && !req_external)
           || (state != EBW_IDLE && end_cycle);
    end
  end

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  logic next_active;
  logic next_write;
  logic next_read;
  logic next_wl;
  logic next_wh;
  logic next_bhe;
  logic [1:0] next_bytes;

  // Strobes held for the whole cycle, released as it ends
  always_comb begin
    next_active = 1'b0;
    next_bytes  = cur_bytes;
    if (state == EBW_IDLE) begin
      next_active = req && req_external;
      next_bytes  = req_bytes;
    end else begin
      next_active = !end_cycle;
    end
    next_write = next_active && ((state == EBW_IDLE) ? req_write : cur_write);
    next_read  = next_active && !((state == EBW_IDLE) ? req_write : cur_write);
    next_wl    = next_write && (!bus16 || next_bytes[0]);
    next_wh    = next_write && (!bus16 || next_bytes[1]);
    next_bhe   = next_active && bus16 && next_bytes[1];
  end

  // Registered active-low pins; write strobes only on external writes
  always_ff @(posedge clk) begin
    if (rst) begin
      read_n             <= 1'b1;
      write_n            <= 1'b1;
      write_low_byte_n   <= 1'b1;
      write_high_byte_n  <= 1'b1;
      byte_high_enable_n <= 1'b1;
      pin_low_strobe_n   <= 1'b1;
      pin_high_strobe_n  <= 1'b1;
      busy               <= 1'b0;
    end else begin
      read_n             <= !next_read;
      write_n            <= !next_write;
      write_low_byte_n   <= !next_wl;
      write_high_byte_n  <= !next_wh;
      byte_high_enable_n <= !next_bhe;
      pin_low_strobe_n   <= sel_split_low  ? !next_wl : !next_write;
      pin_high_strobe_n  <= sel_split_high ? !next_wh : !next_bhe;
      busy               <= next_active;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  write_ext_a: assert property (@(posedge clk) disable iff (rst)
    !write_n |-> ($past(cur_write) || $past(req_write)) && busy)
    else $error("write strobe outside external write");

  read_ext_a: assert property (@(posedge clk) disable iff (rst)
    !read_n |-> write_n && busy)
    else $error("read strobe overlaps write or idle");

  internal_done_a: assert property (@(posedge clk) disable iff (rst)
    (state == EBW_IDLE && req && !req_external) |=> done && busy == 1'b0)
    else $error("internal access not done at once");

  ready_nowait_a: assert property (@(posedge clk) disable iff (rst)
    (state == EBW_DATA && ready) |=> state == EBW_IDLE)
    else $error("wait inserted with ready high");

  wait_limit_a: assert property (@(posedge clk) disable iff (rst)
    (state != EBW_IDLE) |-> wait_cnt <= wait_limit)
    else $error("wait count beyond limit");

  wait_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state != EBW_IDLE && !ready && wait_cnt < wait_limit) |=> state == EBW_WAIT)
    else $error("wait ended with ready low");

  low8_a: assert property (@(posedge clk) disable iff (rst)
    (!bus16 && !$past(bus16)) |-> (write_low_byte_n == write_n))
    else $error("8-bit low strobe mismatch");

  high8_a: assert property (@(posedge clk) disable iff (rst)
    (!bus16 && !$past(bus16)) |-> (write_high_byte_n == write_n))
    else $error("8-bit high strobe mismatch");

  word16_a: assert property (@(posedge clk) disable iff (rst)
    (!write_n && $past(bus16) && $past(next_bytes) == BYTE_WORD) |->
      !write_low_byte_n && !write_high_byte_n)
    else $error("word write misses a byte strobe");

  count_restart_a: assert property (@(posedge clk) disable iff (rst)
    (state == EBW_IDLE) |-> wait_cnt == '0 && write_n && read_n)
    else $error("counter or strobe not cleared between cycles");
endmodule
`default_nettype wire

// ===== ebw_mem_model.sv
// External memory model that drives the ready pin
`timescale 1ns/100ps
`default_nettype none
module ebw_mem_model (
  // Clock and speed
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [4:0] hold,
  // Bus strobes and ready
  input  wire logic       read_n,
  input  wire logic       write_n,
  output logic            ready_pin
);
  int cnt = 0;
  // Strobe age; a hold beyond the longest cycle keeps a slow part waiting
  always @(posedge clk) cnt <= (read_n & write_n) ? 0 : cnt + 1;
  // Slow part holds ready low until it can finish
  assign ready_pin = !slow || cnt >= int'(hold);
endmodule
`default_nettype wire

// ===== ebw_pkg.sv
// Package: constants and types for the external bus write strobe and wait unit
package ebw_pkg;
  // Wait-state limit field width and reset value
  localparam int unsigned WAIT_W          = 4;
  localparam logic [3:0]  WAIT_LIMIT_RST  = 4'h0;
  // Cycle length without wait states (data phase clocks)
  localparam logic [3:0]  NOMINAL_CYCLES  = 4'h1;
  // Byte selects of an access
  localparam logic [1:0]  BYTE_LOW        = 2'h1;
  localparam logic [1:0]  BYTE_HIGH       = 2'h2;
  localparam logic [1:0]  BYTE_WORD       = 2'h3;
  // Controller states
  typedef enum logic [2:0] {
    EBW_IDLE  = 3'b001,
    EBW_DATA  = 3'b010,
    EBW_WAIT  = 3'b100
  } ebw_state_t;
endpackage

// ===== ebw_sync.sv
// Two flip-flop synchroniser for a pin input
`timescale 1ns/100ps
`default_nettype none
module ebw_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin and synchronised level
  input  wire logic pin,
  output logic      level
);
  logic stage1;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 1'b1;
      level  <= 1'b1;
    end else begin
      stage1 <= pin;
      level  <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== ext_bus_write_strobes_wait_tb.sv
// Self-checking bench for the external bus strobe and wait controller
`timescale 1ns/100ps
`default_nettype none
module ext_bus_write_strobes_wait_tb;
  import ebw_pkg::*;
  logic       clk = 0, rst = 1, req = 0, req_external = 0, req_write = 0;
  logic       bus16 = 0, sel_split_low = 0, sel_split_high = 0, slow = 0;
  logic [1:0] req_bytes = BYTE_WORD;
  logic [3:0] wait_limit = WAIT_LIMIT_RST;
  logic [4:0] hold = 5'd20;
  logic       ready_pin, done, read_n, write_n, write_low_byte_n, write_high_byte_n;
  logic       pin_low_strobe_n, pin_high_strobe_n, byte_high_enable_n, busy;
  int         mismatches = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  ebw_ctrl dut (.clk(clk), .rst(rst), .req(req), .req_external(req_external), .req_write(req_write),
    .req_bytes(req_bytes), .done(done), .bus16(bus16), .wait_limit(wait_limit),
    .sel_split_low(sel_split_low), .sel_split_high(sel_split_high), .ready_pin(ready_pin),
    .read_n(read_n), .write_n(write_n), .write_low_byte_n(write_low_byte_n),
    .write_high_byte_n(write_high_byte_n), .pin_low_strobe_n(pin_low_strobe_n),
    .pin_high_strobe_n(pin_high_strobe_n), .byte_high_enable_n(byte_high_enable_n), .busy(busy));
  ebw_mem_model mem (.clk(clk), .slow(slow), .hold(hold), .read_n(read_n), .write_n(write_n),
    .ready_pin(ready_pin));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Raw pin picture: busy then the seven strobes
  function automatic logic [7:0] pins();
    return {busy, read_n, write_n, write_low_byte_n, write_high_byte_n, byte_high_enable_n,
            pin_low_strobe_n, pin_high_strobe_n};
  endfunction
  // Which strobes should go low at some point in the cycle
  function automatic logic [7:0] exp_lows(logic e, logic w, logic [1:0] by);
    logic wl, wh, bh;
    wl = e & w & (!bus16 | by[0]);
    wh = e & w & (!bus16 | by[1]);
    bh = e & bus16 & by[1];
    return {e, e & !w, e & w, wl, wh, bh, sel_split_low ? wl : e & w, sel_split_high ? wh : bh};
  endfunction
  // Edges from take to done: internal one, external nominal plus waits;
  // a slow part frees ready after hold, seen two edges late through the sync
  function automatic int exp_edges(logic e);
    int lim;
    lim = 1 + int'(NOMINAL_CYCLES) + int'(wait_limit);
    if (!e)
      return 1;
    if (!slow)
      return 1 + int'(NOMINAL_CYCLES);
    return (int'(hold) + 4 < lim) ? int'(hold) + 4 : lim;
  endfunction
  task automatic chk(logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (exp !== got) begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One access; edges counted from launch until done is seen
  task automatic access(logic e, logic w, logic [1:0] by);
    logic [7:0] acc, p;
    int n;
    acc = 0;
    n = 0;
    req <= 1;
    req_external <= e;
    req_write <= w;
    req_bytes <= by;
    do begin
      @(posedge clk);
      #1;
      n++;
      p = pins();
      acc |= {p[7], ~p[6:0]};
    end while (done !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      complete_run();
    end
    chk(exp_lows(e, w, by), acc);
    chk(8'(exp_edges(e)), 8'(n));
    @(negedge clk);
    req <= 0;
    chk(8'h7f, pins());
    repeat (3) @(negedge clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h2fec051a));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst <= 0;
    chk(8'h7f, pins());
    @(negedge clk);
    // Corners: slow part at both limit ends, internal access while not ready
    slow = 1;
    access(1, 1, BYTE_LOW);
    wait_limit = 4'hf;
    access(1, 0, BYTE_WORD);
    access(1, 1, BYTE_HIGH);
    access(0, 1, BYTE_WORD);
    $display("test corners done");
    repeat (60) begin
      {bus16, sel_split_low, sel_split_high, slow} = 4'($urandom);
      wait_limit = 4'($urandom);
      hold = 5'($urandom_range(12, 1));
      // Let the ready synchroniser settle on the new memory speed
      repeat (2) @(negedge clk);
      access(1'($urandom), 1'($urandom), 2'($urandom_range(3, 1)));
    end
    $display("test random done");
    complete_run();
  end
endmodule
`default_nettype wire
